// ### rtl/bsc_exec.sv
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_exec (
   input  wire logic              core_clk_i,
   input  wire logic              reset_i,
   input  wire bsc_pkg::bsc_instr_t instr_i,
   input  wire bsc_pkg::bsc_data_t  reg_data_i,
   input  wire bsc_pkg::bsc_data_t  pc_page_latch_i,
   output logic                   cycle_start_o,
   output bsc_pkg::bsc_pc_t       pc_o,
   output bsc_pkg::bsc_faddr_t    reg_addr_o,
   output logic                   reg_rd_o,
   output logic                   push_o,
   output bsc_pkg::bsc_pc_t       stack_top_o,
   output logic                   exec_nop_o
);
   import bsc_pkg::*;

   bsc_phase_if ph ();

   bsc_qphase u_qphase (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .ph         (ph.seq)
   );

   bsc_instr_t ir_q;
   bsc_pc_t    exec_pc_q;
   bsc_op_t    op_q;
   bsc_op_t    op_d;
   logic       exec_nop_q;
   logic       flush_q;
   logic       bit_set_q;
   logic [`BSC_B_MSB-`BSC_B_LSB:0] bit_sel;
   logic [`BSC_K_MSB:0]            call_k;
   bsc_pc_t    call_target;

   // decode of the word fetched at the start of the cycle
   always_comb
   begin
      op_d = BSC_OP_OTHER;
      if (instr_i[`BSC_OPC_BT_MSB:`BSC_OPC_BT_LSB] == `BSC_OPC_BIT_TEST)
      begin
         op_d = BSC_OP_BIT_TEST_SKIP_IF_SET;
      end
      else if (instr_i[`BSC_OPC_CA_MSB:`BSC_OPC_CA_LSB] == `BSC_OPC_CALL)
      begin
         op_d = BSC_OP_CALL;
      end
   end

   assign bit_sel     = ir_q[`BSC_B_MSB:`BSC_B_LSB];
   assign call_k      = ir_q[`BSC_K_MSB:`BSC_K_LSB];
   assign call_target = {pc_page_latch_i[`BSC_PAGE_MSB:`BSC_PAGE_LSB], call_k};

   // Q1: latch the instruction, or a NOP when the previous cycle asked for it
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         ir_q       <= `BSC_INSTR_NOP;
         op_q       <= BSC_OP_OTHER;
         exec_pc_q  <= `BSC_PC_RST;
         exec_nop_q <= 1'b1;
      end
      else if (ph.q1)
      begin
         exec_pc_q  <= pc_o;
         exec_nop_q <= flush_q;
         if (flush_q)
         begin
            ir_q <= `BSC_INSTR_NOP;
            op_q <= BSC_OP_OTHER;
         end
         else
         begin
            ir_q <= instr_i;
            op_q <= op_d;
         end
      end
   end

   assign exec_nop_o = exec_nop_q;

   // cycle marker, high during the Q1 clock
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         cycle_start_o <= 1'b0;
      end
      else
      begin
         cycle_start_o <= ph.q4;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         reg_addr_o <= `BSC_ADDR_RST;
         reg_rd_o   <= 1'b0;
      end
      else if (ph.q2 && op_q == BSC_OP_BIT_TEST_SKIP_IF_SET)
      begin
         reg_addr_o <= ir_q[`BSC_F_MSB:`BSC_F_LSB];
         reg_rd_o   <= 1'b1;
      end
      else
      begin
         reg_rd_o   <= 1'b0;
      end
   end

   // test the selected bit in Q3, no flags touched
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         bit_set_q <= 1'b0;
      end
      else if (ph.q3)
      begin
         bit_set_q <= reg_rd_o & reg_data_i[bit_sel];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         push_o      <= 1'b0;
         stack_top_o <= `BSC_PC_RST;
      end
      else if (ph.q2 && op_q == BSC_OP_CALL)
      begin
         push_o      <= 1'b1;
         stack_top_o <= exec_pc_q + `BSC_PC_STEP;
      end
      else
      begin
         push_o      <= 1'b0;
      end
   end

   // Q4: program counter update; a forced NOP cycle holds it, because the
   // discarded word has already been stepped over by the cycle before
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         pc_o <= `BSC_PC_RST;
      end
      else if (ph.q4 && !exec_nop_q)
      begin
         unique case (op_q)
            BSC_OP_CALL:
               pc_o <= call_target;
            BSC_OP_BIT_TEST_SKIP_IF_SET:
               pc_o <= bit_set_q ? pc_o + `BSC_PC_SKIP : pc_o + `BSC_PC_STEP;
            BSC_OP_OTHER:
               pc_o <= pc_o + `BSC_PC_STEP;
         endcase
      end
   end

   // Q4: request a NOP for the following cycle
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         flush_q <= 1'b0;
      end
      else if (ph.q4)
      begin
         flush_q <= !exec_nop_q &&
                    ((op_q == BSC_OP_CALL) ||
                     (op_q == BSC_OP_BIT_TEST_SKIP_IF_SET && bit_set_q));
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_test_q4;
      ph.q4 && !exec_nop_q && op_q == BSC_OP_BIT_TEST_SKIP_IF_SET;
   endsequence

   sequence s_call_q2;
      ph.q2 && !exec_nop_q && op_q == BSC_OP_CALL;
   endsequence

   sequence s_call_q4;
      ph.q4 && !exec_nop_q && op_q == BSC_OP_CALL;
   endsequence

   property p_bit_clear_runs_next;
      s_test_q4 ##0 !bit_set_q |-> ##1 ph.q1 ##1 !exec_nop_q;
   endproperty
   a_bit_clear_runs_next: assert property (p_bit_clear_runs_next)
      else $error("bit clear but next cycle was a NOP");

   property p_bit_set_skips;
      s_test_q4 ##0 bit_set_q |-> ##2 exec_nop_q [*4] ##1 !exec_nop_q;
   endproperty
   a_bit_set_skips: assert property (p_bit_set_skips)
      else $error("bit set but no single NOP cycle followed");

   property p_skip_pc_step;
      s_test_q4 ##0 bit_set_q |=> pc_o == $past(pc_o) + `BSC_PC_SKIP;
   endproperty
   a_skip_pc_step: assert property (p_skip_pc_step)
      else $error("skip did not step over the next word");

   property p_call_target;
      s_call_q4 |=> pc_o == {$past(pc_page_latch_i[`BSC_PAGE_MSB:`BSC_PAGE_LSB]),
                             $past(ir_q[`BSC_K_MSB:`BSC_K_LSB])};
   endproperty
   a_call_target: assert property (p_call_target)
      else $error("call target not literal with page bits");

   property p_call_push;
      s_call_q2 |=> push_o && stack_top_o == $past(exec_pc_q) + `BSC_PC_STEP
                    ##1 !push_o ##2 exec_nop_q [*4];
   endproperty
   a_call_push: assert property (p_call_push)
      else $error("call push or second NOP cycle wrong");

   property p_call_top_literal;
      s_call_q4 ##0 ir_q[`BSC_K_MSB:`BSC_K_LSB] == 11'h7FF |=> pc_o[`BSC_K_MSB:0] == 11'h7FF;
   endproperty
   a_call_top_literal: assert property (p_call_top_literal)
      else $error("call to top literal 2047 lost bits");

   property p_test_reads_f;
      ph.q2 && op_q == BSC_OP_BIT_TEST_SKIP_IF_SET |=>
         reg_rd_o && !push_o && reg_addr_o == $past(ir_q[`BSC_F_MSB:`BSC_F_LSB]);
   endproperty
   a_test_reads_f: assert property (p_test_reads_f)
      else $error("bit test did not read register f");

   property p_push_only_on_call;
      $rose(push_o) |-> $past(op_q) == BSC_OP_CALL && $past(ph.q2);
   endproperty
   a_push_only_on_call: assert property (p_push_only_on_call)
      else $error("push without a call");
endmodule : bsc_exec

// ### rtl/bsc_params.svh
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// widths
`define BSC_PC_W        13
`define BSC_INSTR_W     14
`define BSC_DATA_W      8
`define BSC_PH_W        4

// opcode fields of the 14-bit instruction word
`define BSC_OPC_BT_MSB  13
`define BSC_OPC_BT_LSB  10
`define BSC_OPC_BIT_TEST 4'h7
`define BSC_OPC_CA_MSB  13
`define BSC_OPC_CA_LSB  11
`define BSC_OPC_CALL    3'h4

// operand fields
`define BSC_F_MSB       6
`define BSC_F_LSB       0
`define BSC_B_MSB       9
`define BSC_B_LSB       7
`define BSC_K_MSB       10
`define BSC_K_LSB       0
`define BSC_PAGE_MSB    4
`define BSC_PAGE_LSB    3

// reset values and steps
`define BSC_PC_RST      13'h0000
`define BSC_INSTR_NOP   14'h0000
`define BSC_ADDR_RST    7'h00
`define BSC_PC_STEP     13'h0001
`define BSC_PC_SKIP     13'h0002
`define BSC_PH_RST      4'h1

// one-hot phase positions
`define BSC_PH_Q1       0
`define BSC_PH_Q2       1
`define BSC_PH_Q3       2
`define BSC_PH_Q4       3

`endif

// ### rtl/bsc_phase_if.sv
`timescale 1ns/1ps

// one-cycle enables for the four phases of an instruction cycle
interface bsc_phase_if;
   logic q1;
   logic q2;
   logic q3;
   logic q4;

   modport seq  (output q1, output q2, output q3, output q4);
   modport core (input q1, input q2, input q3, input q4);
endinterface : bsc_phase_if

// ### rtl/bsc_pkg.sv
`include "bsc_params.svh"

package bsc_pkg;
   typedef logic [`BSC_PC_W-1:0]    bsc_pc_t;
   typedef logic [`BSC_INSTR_W-1:0] bsc_instr_t;
   typedef logic [`BSC_DATA_W-1:0]  bsc_data_t;
   typedef logic [`BSC_F_MSB:0]     bsc_faddr_t;

   typedef enum logic [1:0] {
      BSC_OP_OTHER,
      BSC_OP_BIT_TEST_SKIP_IF_SET,
      BSC_OP_CALL
   } bsc_op_t;
endpackage : bsc_pkg

// ### rtl/bsc_qphase.sv
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_qphase (
   input  wire logic    core_clk_i,
   input  wire logic    reset_i,
   bsc_phase_if.seq     ph
);
   import bsc_pkg::*;

   logic [`BSC_PH_W-1:0] ring_q;

   // one-hot ring: each phase lasts one clock, four clocks per instruction
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         ring_q <= `BSC_PH_RST;
      end
      else
      begin
         ring_q <= {ring_q[`BSC_PH_W-2:0], ring_q[`BSC_PH_W-1]};
      end
   end

   assign ph.q1 = ring_q[`BSC_PH_Q1];
   assign ph.q2 = ring_q[`BSC_PH_Q2];
   assign ph.q3 = ring_q[`BSC_PH_Q3];
   assign ph.q4 = ring_q[`BSC_PH_Q4];
endmodule : bsc_qphase

// ### verif/bsc_far_model.sv
`timescale 1ns/1ps

module bsc_far_model (
   input  wire bsc_pkg::bsc_pc_t    pc_i,
   input  wire bsc_pkg::bsc_faddr_t reg_addr_i,
   input  wire logic                reg_rd_i,
   output bsc_pkg::bsc_instr_t      instr_o,
   output bsc_pkg::bsc_data_t       reg_data_o
);
   import bsc_pkg::*;

   bsc_instr_t mem  [0:8191];
   bsc_data_t  regs [0:127];

   assign instr_o = mem[pc_i];
   // outside a read the bus shows inverted data so stale values cannot pass
   assign reg_data_o = reg_rd_i ? regs[reg_addr_i] : ~regs[reg_addr_i];
endmodule : bsc_far_model

// ### verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   import bsc_pkg::*;

   localparam int N_CYC = 64;

   logic        core_clk_i;
   logic        reset_i;
   bsc_instr_t  instr_i;
   bsc_data_t   reg_data_i;
   bsc_data_t   pc_page_latch_i;
   logic        cycle_start_o;
   bsc_pc_t     pc_o;
   bsc_faddr_t  reg_addr_o;
   logic        reg_rd_o;
   logic        push_o;
   bsc_pc_t     stack_top_o;
   logic        exec_nop_o;
   integer      seed = 65843;
   int          n_mismatch = 0;
   int          check_count = 0;
   logic [15:0] exp_q [$];
   bit          wr [0:8191];

   bsc_exec u_bsc_exec (
      .core_clk_i      (core_clk_i),
      .reset_i         (reset_i),
      .instr_i         (instr_i),
      .reg_data_i      (reg_data_i),
      .pc_page_latch_i (pc_page_latch_i),
      .cycle_start_o   (cycle_start_o),
      .pc_o            (pc_o),
      .reg_addr_o      (reg_addr_o),
      .reg_rd_o        (reg_rd_o),
      .push_o          (push_o),
      .stack_top_o     (stack_top_o),
      .exec_nop_o      (exec_nop_o)
   );

   bsc_far_model u_bsc_far_model (
      .pc_i       (pc_o),
      .reg_addr_i (reg_addr_o),
      .reg_rd_i   (reg_rd_o),
      .instr_o    (instr_i),
      .reg_data_o (reg_data_i)
   );

   initial core_clk_i = 1'b0;
   always #10 core_clk_i = ~core_clk_i;

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
      check_count++;
      if (seen !== expv)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
      end
   endtask : check

   task automatic close_out();
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // reference walk of the program; words are coined the first time they are reached
   task automatic build_run();
      bsc_pc_t    pc;
      logic       nop;
      logic       last;
      bsc_instr_t w;
      logic [31:0] k;
      int         r;
      pc = 13'h0000;
      nop = 1'b0;
      last = 1'b0;
      exp_q.delete();
      for (int a = 0; a < 8192; a++)
      begin
         u_bsc_far_model.mem[a] = 14'h0000;
         wr[a] = 1'b0;
      end
      for (int a = 0; a < 128; a++)
         u_bsc_far_model.regs[a] = $random(seed);
      for (int i = 0; i < N_CYC; i++)
      begin
         // exec_nop_o turns over at the Q1 edge, so the marker clock still shows
         // the flag of the cycle before
         if (i > 0)
            exp_q.push_back({2'h0, pc, last});
         last = nop;
         k = $random(seed);
         if (nop)
            nop = 1'b0;
         else
         begin
            if (!wr[pc])
            begin
               r = k[31:30];
               if (r < 2)
                  w = {4'h7, k[9:7], (i % 7 == 1) ? 7'h7F : k[6:0]};
               else if (r == 2)
                  w = {3'h4, (i < 8) ? {11{i[1]}} : k[10:0]};
               else
                  w = {2'b00, k[11:0]};
               u_bsc_far_model.mem[pc] = w;
               wr[pc] = 1'b1;
            end
            w = u_bsc_far_model.mem[pc];
            if (w[13:10] == 4'h7)
            begin
               exp_q.push_back({2'h1, 7'h00, w[6:0]});
               if (u_bsc_far_model.regs[w[6:0]][w[9:7]])
               begin
                  // a call in the skipped slot must leave no push behind
                  if (!wr[pc + 13'h0001])
                     u_bsc_far_model.mem[pc + 13'h0001] = {3'h4, k[20:10]};
                  pc = pc + 13'h0002;
                  nop = 1'b1;
               end
               else
                  pc = pc + 13'h0001;
            end
            else if (w[13:11] == 3'h4)
            begin
               exp_q.push_back({2'h2, 1'b0, pc + 13'h0001});
               pc = {pc_page_latch_i[4:3], w[10:0]};
               nop = 1'b1;
            end
            else
               pc = pc + 13'h0001;
         end
      end
   endtask : build_run

   function automatic logic [15:0] pop_exp();
      return exp_q.pop_front();
   endfunction : pop_exp

   // look mid-clock, where the registered outputs have settled
   always @(negedge core_clk_i)
   begin
      if (reset_i === 1'b0 && exp_q.size() > 0)
      begin
         if (cycle_start_o === 1'b1)
            check("cycle pc/nop", {2'h0, pc_o, exec_nop_o}, pop_exp());
         if (reg_rd_o === 1'b1)
            check("reg read addr", {2'h1, 7'h00, reg_addr_o}, pop_exp());
         if (push_o === 1'b1)
            check("push value", {3'h4, stack_top_o}, pop_exp());
      end
   end

   initial
   begin
      #50000;
      n_mismatch++;
      close_out();
   end

   initial
   begin
      reset_i = 1'b1;
      pc_page_latch_i = 8'h00;
      for (int run = 0; run < 2; run++)
      begin
         @(negedge core_clk_i);
         reset_i = 1'b1;
         pc_page_latch_i = $random(seed);
         build_run();
         repeat (10) @(negedge core_clk_i);
         check("reset state", {pc_o, exec_nop_o, push_o, reg_rd_o}, 16'h0004);
         reset_i = 1'b0;
         repeat (N_CYC * 4 + 8) @(negedge core_clk_i);
         check("events left", exp_q.size(), 16'h0000);
      end
      close_out();
   end
endmodule : tb_top
